/* File: core/dco_pkg.sv */
/*
 * constants for the digital oscillator loop and clock monitor block.
 * assumes a single mclk domain at 25 MHz and an APB register bus.
 */
// Function
// - monitor drops dead selected source, switches to other
// - divider is two to exponent, capped at 512
// - exponent moves only on stage carry/borrow or a divider write
// - upper stage bits give 17 to 31 stages
// - lower stage bits set long cycles per 32
// - top code alternates 31 and 17 halved
// - each correction spans four base periods
// - coarse steps of stage bit five above 15 percent
// - smallest correction is one stage lsb
// - internal clock tracks factor times base clock
// - monitor enable refused until stable after factor change
// - loop restarts after reset, factor, trim, re-enable
// - factor changes take effect immediately; divider and stage writes need internal off
// - select bit routes external when set, internal clear
// - monitor works only with both sources on, stable
package dco_pkg;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MULT = 8'h04;
	localparam logic [7:0] OFS_TRIM = 8'h08;
	localparam logic [7:0] OFS_DIV = 8'h0C;
	localparam logic [7:0] OFS_STG = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;
	// control bit positions
	localparam int B_SEL = 0;
	localparam int B_EXT_ON = 1;
	localparam int B_INT_ON = 2;
	localparam int B_MON = 3;
	localparam int B_FLAG = 4;
	localparam int B_INT_STB = 5;
	localparam int B_EXT_STB = 6;
	localparam logic [6:0] CTRL_RST = 7'h06;
	localparam logic [6:0] MULT_RST = 7'h15;
	localparam logic [7:0] TRIM_RST = 8'h80;
	localparam logic [3:0] DIV_RST = 4'h0;
	localparam logic [7:0] STG_RST = 8'h80;
	localparam logic [3:0] DIV_MAX = 4'h9;
	localparam int CORR_BASE = 4;
	localparam logic [7:0] COARSE_STEP = 8'h20;
	localparam logic [7:0] FINE_STEP = 8'h01;
	localparam int COARSE_PCT = 15;
	localparam int FRAME = 32;
	localparam int BASE_STAGES = 17;
	localparam int TOP_STAGES = 31;
	localparam int HALVED_STAGES = 34;
	localparam logic [2:0] TOP_CODE = 3'h7;
	function automatic logic [9:0] ring_len(input logic [2:0] up);
		ring_len = 10'(BASE_STAGES) + {6'h00, up, 1'b0};
	endfunction
endpackage

/* File: core/period_counter.sv */
/*
 * counts mclk cycles between base clock sample edges.
 * assumes base_tick is a one-cycle pulse in the mclk domain.
 */
`timescale 1ns/1ps
module period_counter (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clear,
	input wire logic base_tick,
	output logic [15:0] cycles,
	output logic done
);
	logic [15:0] cnt_r, cnt_nxt, cyc_r, cyc_nxt;
	logic [2:0] ticks_r, ticks_nxt;
	logic done_r, done_nxt;
	always_comb begin
		cnt_nxt = cnt_r + 16'h0001;
		ticks_nxt = ticks_r;
		cyc_nxt = cyc_r;
		done_nxt = 1'b0;
		if (clear) begin
			cnt_nxt = 16'h0000;
			ticks_nxt = 3'h0;
		end else if (base_tick) begin
			// window of four base periods
			if (ticks_r == 3'(dco_pkg::CORR_BASE - 1)) begin
				cyc_nxt = cnt_r;
				done_nxt = 1'b1;
				cnt_nxt = 16'h0000;
				ticks_nxt = 3'h0;
			end else begin
				ticks_nxt = ticks_r + 3'h1;
			end
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= 16'h0000;
			cyc_r <= 16'h0000;
			ticks_r <= 3'h0;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			cyc_r <= cyc_nxt;
			ticks_r <= ticks_nxt;
			done_r <= done_nxt;
		end
	end
	assign cycles = cyc_r;
	assign done = done_r;
endmodule

/* File: core/dco_loop.sv */
/*
 * loop filter, divider/ring control and clock monitor with APB slave.
 * assumes internal clock activity pulses and base ticks are mclk-synchronous.
 */
`timescale 1ns/1ps
module dco_loop (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic base_tick,
	input wire logic internal_clock_tick,
	input wire logic int_off,
	input wire logic ext_off,
	input wire logic ext_stable,
	output logic sel_external,
	output logic ring_long,
	output logic ring_halve,
	output logic [9:0] ring_stages,
	output logic [3:0] divider_exponent,
	output logic [7:0] stage_control,
	output logic monitor_flag
);
	logic [6:0] ctrl_r, ctrl_nxt;
	logic [6:0] mult_r, mult_nxt;
	logic [7:0] trim_r, trim_nxt;
	logic [3:0] div_r, div_nxt;
	logic [7:0] stg_r, stg_nxt;
	logic stable_r, stable_nxt;
	logic mflag_r, mflag_nxt;
	logic flag_seen_r, flag_seen_nxt;
	logic [4:0] frame_r, frame_nxt;
	logic [3:0] good_r, good_nxt;
	logic [15:0] icnt_r, icnt_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic restart;
	logic [15:0] meas_cycles;
	logic meas_done;
	logic wr, rd;
	logic [17:0] target;
	logic [17:0] diff;
	logic coarse, slow, on_target;
	logic [8:0] stg_sum;
	logic fine_long;

	////////////////////////////////////////////////////////////////////
	// bus decode
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !(paddr == dco_pkg::OFS_CTRL
		|| paddr == dco_pkg::OFS_MULT || paddr == dco_pkg::OFS_TRIM
		|| paddr == dco_pkg::OFS_DIV || paddr == dco_pkg::OFS_STG
		|| paddr == dco_pkg::OFS_STAT);

	// settling restarts on factor/trim writes and internal re-enable
	assign restart = (wr && (paddr == dco_pkg::OFS_MULT
		|| paddr == dco_pkg::OFS_TRIM))
		|| (!ctrl_r[dco_pkg::B_INT_ON]);

	period_counter u_meas (
		.mclk(mclk),
		.nrst(nrst),
		.clear(restart),
		.base_tick(base_tick),
		.cycles(),
		.done(meas_done)
	);
	assign meas_cycles = icnt_r;

	////////////////////////////////////////////////////////////////////
	// loop filter
	// target: four base periods hold 4*N internal cycles
	assign target = {9'h000, mult_r, 2'b00};
	assign slow = {2'b00, meas_cycles} < target;
	assign diff = slow ? target - {2'b00, meas_cycles}
		: {2'b00, meas_cycles} - target;
	// coarse while error above 15 percent
	assign coarse = ({7'h00, diff} * 25'd100)
		> ({7'h00, target} * 25'(dco_pkg::COARSE_PCT));
	assign on_target = diff == 18'h00000;

	always_comb begin
		icnt_nxt = icnt_r;
		if (restart || meas_done)
			icnt_nxt = 16'h0000;
		else if (internal_clock_tick)
			icnt_nxt = icnt_r + 16'h0001;
		stg_nxt = stg_r;
		div_nxt = div_r;
		stg_sum = 9'h000;
		stable_nxt = stable_r;
		good_nxt = good_r;
		if (restart) begin
			stable_nxt = 1'b0;
			good_nxt = 4'h0;
		end
		if (meas_done && !restart && !on_target) begin
			// too few internal cycles: shorten period, else lengthen
			if (slow) begin
				stg_sum = {1'b0, stg_r} - {1'b0, coarse
					? dco_pkg::COARSE_STEP : dco_pkg::FINE_STEP};
				// borrow halves period via exponent
				if (stg_sum[8]) begin
					if (div_r != 4'h0) begin
						div_nxt = div_r - 4'h1;
						stg_nxt = stg_sum[7:0];
					end else begin
						stg_nxt = 8'h00;
					end
				end else begin
					stg_nxt = stg_sum[7:0];
				end
			end else begin
				stg_sum = {1'b0, stg_r} + {1'b0, coarse
					? dco_pkg::COARSE_STEP : dco_pkg::FINE_STEP};
				// carry doubles period via exponent
				if (stg_sum[8]) begin
					if (div_r < dco_pkg::DIV_MAX) begin
						div_nxt = div_r + 4'h1;
						stg_nxt = stg_sum[7:0];
					end else begin
						stg_nxt = 8'hFF;
					end
				end else begin
					stg_nxt = stg_sum[7:0];
				end
			end
		end
		if (meas_done && !restart) begin
			if (!coarse)
				good_nxt = (good_r == 4'hF) ? good_r : good_r + 4'h1;
			else
				good_nxt = 4'h0;
			stable_nxt = !coarse && good_r >= 4'h7;
		end
		// divider and stage writes allowed only while internal generator is off
		if (wr && !ctrl_r[dco_pkg::B_INT_ON]) begin
			if (paddr == dco_pkg::OFS_DIV)
				div_nxt = pwdata[3:0];
			if (paddr == dco_pkg::OFS_STG)
				stg_nxt = pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// ring and fine adjust
	always_comb begin
		frame_nxt = frame_r + 5'h01;
		// long length for stage[4:0] cycles of each 32
		fine_long = frame_r < stg_r[4:0];
	end
	assign ring_long = fine_long;
	// top code: 31 when long, else 17 halved for 34
	assign ring_halve = (stg_r[7:5] == dco_pkg::TOP_CODE) && !fine_long;
	always_comb begin
		if (stg_r[7:5] == dco_pkg::TOP_CODE)
			ring_stages = fine_long ? 10'(dco_pkg::TOP_STAGES)
				: 10'(dco_pkg::HALVED_STAGES);
		else
			ring_stages = dco_pkg::ring_len(stg_r[7:5])
				+ (fine_long ? 10'h002 : 10'h000);
	end
	// saturate codes above nine to nine
	assign divider_exponent = (div_r > dco_pkg::DIV_MAX)
		? dco_pkg::DIV_MAX : div_r;
	assign stage_control = stg_r;

	////////////////////////////////////////////////////////////////////
	// control register and monitor
	always_comb begin
		ctrl_nxt = ctrl_r;
		mult_nxt = mult_r;
		trim_nxt = trim_r;
		mflag_nxt = mflag_r;
		flag_seen_nxt = flag_seen_r;
		if (rd && paddr == dco_pkg::OFS_CTRL && mflag_r)
			flag_seen_nxt = 1'b1;
		if (wr && paddr == dco_pkg::OFS_CTRL) begin
			ctrl_nxt[dco_pkg::B_SEL] = pwdata[dco_pkg::B_SEL];
			ctrl_nxt[dco_pkg::B_EXT_ON] = pwdata[dco_pkg::B_EXT_ON];
			ctrl_nxt[dco_pkg::B_INT_ON] = pwdata[dco_pkg::B_INT_ON];
			// enable only with both on and stable
			ctrl_nxt[dco_pkg::B_MON] = pwdata[dco_pkg::B_MON]
				&& pwdata[dco_pkg::B_EXT_ON] && pwdata[dco_pkg::B_INT_ON]
				&& ctrl_r[dco_pkg::B_EXT_ON] && ctrl_r[dco_pkg::B_INT_ON]
				&& stable_r && ext_stable;
			// read then write of zero clears flag
			if (flag_seen_r && !pwdata[dco_pkg::B_FLAG]) begin
				mflag_nxt = 1'b0;
				flag_seen_nxt = 1'b0;
			end
		end
		// new factor takes effect at once
		if (wr && paddr == dco_pkg::OFS_MULT)
			mult_nxt = pwdata[6:0];
		if (wr && paddr == dco_pkg::OFS_TRIM)
			trim_nxt = pwdata[7:0];
		// dead source dropped, live one selected; set beats clear
		if (ctrl_r[dco_pkg::B_MON]) begin
			if (ctrl_r[dco_pkg::B_SEL] && ext_off) begin
				ctrl_nxt[dco_pkg::B_SEL] = 1'b0;
				mflag_nxt = 1'b1;
			end else if (!ctrl_r[dco_pkg::B_SEL] && int_off) begin
				ctrl_nxt[dco_pkg::B_SEL] = 1'b1;
				mflag_nxt = 1'b1;
			end
		end
		rdata_nxt = 32'h00000000;
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				dco_pkg::OFS_CTRL: rdata_nxt = {25'h0000000, ext_stable,
					stable_r, mflag_r, ctrl_r[3:0]};
				dco_pkg::OFS_MULT: rdata_nxt = {25'h0000000, mult_r};
				dco_pkg::OFS_TRIM: rdata_nxt = {24'h000000, trim_r};
				dco_pkg::OFS_DIV: rdata_nxt = {28'h0000000, div_r};
				dco_pkg::OFS_STG: rdata_nxt = {24'h000000, stg_r};
				dco_pkg::OFS_STAT: rdata_nxt = {27'h0000000, frame_r};
				default: rdata_nxt = 32'h00000000;
			endcase
		end else begin
			rdata_nxt = rdata_r;
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r <= dco_pkg::CTRL_RST;
			mult_r <= dco_pkg::MULT_RST;
			trim_r <= dco_pkg::TRIM_RST;
			div_r <= dco_pkg::DIV_RST;
			stg_r <= dco_pkg::STG_RST;
			stable_r <= 1'b0;
			mflag_r <= 1'b0;
			flag_seen_r <= 1'b0;
			frame_r <= 5'h00;
			good_r <= 4'h0;
			icnt_r <= 16'h0000;
			rdata_r <= 32'h00000000;
		end else begin
			ctrl_r <= ctrl_nxt;
			mult_r <= mult_nxt;
			trim_r <= trim_nxt;
			div_r <= div_nxt;
			stg_r <= stg_nxt;
			stable_r <= stable_nxt;
			mflag_r <= mflag_nxt;
			flag_seen_r <= flag_seen_nxt;
			frame_r <= frame_nxt;
			good_r <= good_nxt;
			icnt_r <= icnt_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	// external when set, internal when clear
	assign sel_external = ctrl_r[dco_pkg::B_SEL];
	assign monitor_flag = mflag_r;
	assign prdata = rdata_r;
endmodule

/* File: test/dco_loop_monitor.sv */
/*
 * port checker for dco_loop: ring length, loop steps, monitor switch.
 * assumes one mclk domain; bound to every dco_loop below.
 */
`timescale 1ns/1ps
module dco_loop_monitor (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pslverr,
	input wire logic sel_external,
	input wire logic ring_long,
	input wire logic ring_halve,
	input wire logic [9:0] ring_stages,
	input wire logic [3:0] divider_exponent,
	input wire logic [7:0] stage_control,
	input wire logic monitor_flag
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire logic wr = psel && penable && pwrite;
	wire logic [9:0] base = 10'h011 + {6'h00, stage_control[7:5], 1'b0};
	////////////////////////////////////////////////////////////////////////
	a_div_limit: assert property (divider_exponent <= 4'h9)
		else $error("exponent above nine");
	a_base_len: assert property (!ring_long && !ring_halve |->
		ring_stages == base) else $error("base ring length wrong");
	a_long_len: assert property (ring_long && stage_control[7:5] != 3'h7
		|-> ring_stages == base + 10'h002) else $error("long length wrong");
	a_halve_top: assert property (ring_halve |->
		stage_control[7:5] == 3'h7) else $error("halve outside top code");
	a_exp_carry: assert property ($changed(divider_exponent) &&
		!$past(wr) |-> stage_control[7] != $past(stage_control[7]))
		else $error("exponent moved without carry");
	a_stage_step: assert property ($changed(stage_control) &&
		!$past(wr) |-> 8'(stage_control - $past(stage_control)) inside
		{8'h01, 8'hFF, 8'h20, 8'hE0}
		|| (stage_control == 8'h00 && divider_exponent == 4'h0)
		|| (stage_control == 8'hFF && divider_exponent == 4'h9))
		else $error("stage step size wrong");
	a_mon_switch: assert property ($rose(monitor_flag) |->
		$changed(sel_external)) else $error("flag without switch");
	a_sel_cause: assert property ($changed(sel_external) |->
		$past(wr) || $rose(monitor_flag)) else $error("select moved alone");
	a_err_access: assert property (pslverr |-> psel && penable)
		else $error("error outside access");
	c_flag: cover property ($rose(monitor_flag));
	c_halve: cover property (ring_halve);
	c_exp: cover property ($changed(divider_exponent));
endmodule

bind dco_loop dco_loop_monitor i_dco_loop_monitor (.mclk(mclk), .nrst(nrst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pslverr(pslverr),
	.sel_external(sel_external), .ring_long(ring_long),
	.ring_halve(ring_halve), .ring_stages(ring_stages),
	.divider_exponent(divider_exponent), .stage_control(stage_control),
	.monitor_flag(monitor_flag));

/* File: test/test_dco_loop.sv */
/*
 * bench for dco_loop: apb access, ring frame table, loop, monitor, reset.
 * assumes the port checker is bound to the design.
 */
`timescale 1ns/1ps
module test_dco_loop;
	logic mclk, nrst, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr, stage_control;
	logic [31:0] pwdata, prdata, q;
	logic base_tick, internal_clock_tick, int_off, ext_off, ext_stable;
	logic sel_external, ring_long, ring_halve, monitor_flag;
	logic [9:0] ring_stages;
	logic [3:0] divider_exponent;
	int mismatches = 0, n_tests = 0, bper = 0, bcnt = 0, i, j, nl, nb;
	typedef struct {logic [7:0] stg; logic [9:0] len;} row_type;
	row_type rows[4] = '{'{8'h00, 10'h011}, '{8'h61, 10'h017},
		'{8'h7F, 10'h017}, '{8'hE5, 10'h022}};
	dco_loop i_dco_loop (.mclk(mclk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.base_tick(base_tick), .internal_clock_tick(internal_clock_tick), .int_off(int_off),
		.ext_off(ext_off), .ext_stable(ext_stable),
		.sel_external(sel_external), .ring_long(ring_long),
		.ring_halve(ring_halve), .ring_stages(ring_stages),
		.divider_exponent(divider_exponent), .stage_control(stage_control),
		.monitor_flag(monitor_flag));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		bcnt <= (bcnt + 1 >= bper) ? 0 : bcnt + 1;
		base_tick <= bper != 0 && bcnt == 0;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic hang;
		mismatches++;
		stop_test();
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, got);
		n_tests++;
		if (got !== ex) begin
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
			mismatches++;
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge mclk);
			if (pready === 1'b1)
				break;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 20)
			hang();
	endtask
	task automatic corr(input logic [3:0] dv, input logic [7:0] st,
		input int per, input logic [7:0] ex, input logic [3:0] xe);
		xfer(1'b1, dco_pkg::OFS_CTRL, 32'h03);
		xfer(1'b1, dco_pkg::OFS_DIV, {28'h0, dv});
		xfer(1'b1, dco_pkg::OFS_STG, {24'h0, st});
		xfer(1'b1, dco_pkg::OFS_CTRL, 32'h07);
		bper = per;
		for (j = 0; j < 400 && stage_control === st; j++)
			@(posedge mclk);
		bper = 0;
		if (j == 400)
			hang();
		chk("stage", {24'h0, ex}, {24'h0, stage_control});
		chk("exponent", {28'h0, xe}, {28'h0, divider_exponent});
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		base_tick = 1'b0;
		internal_clock_tick = 1'b1;
		int_off = 1'b0;
		ext_off = 1'b0;
		ext_stable = 1'b1;
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		xfer(1'b1, dco_pkg::OFS_CTRL, 32'h07);
		xfer(1'b1, dco_pkg::OFS_CTRL, 32'h03);
		foreach (rows[r]) begin
			xfer(1'b1, dco_pkg::OFS_STG, {24'h0, rows[r].stg});
			xfer(1'b1, dco_pkg::OFS_CTRL, 32'h07);
			nl = 0;
			nb = 0;
			repeat (32) begin
				@(posedge mclk);
				nl += ring_long;
				nb += !ring_long && ring_stages === rows[r].len
					&& ring_halve === (rows[r].stg[7:5] == 3'h7);
			end
			chk("long cycles", rows[r].stg[4:0], nl);
			chk("base cycles", 32 - rows[r].stg[4:0], nb);
			xfer(1'b1, dco_pkg::OFS_CTRL, 32'h03);
		end
		corr(4'h0, 8'h10, 2, 8'h00, 4'h0);
		corr(4'h3, 8'hF0, 40, 8'h10, 4'h4);
		corr(4'h3, 8'h10, 2, 8'hF0, 4'h2);
		corr(4'hC, 8'hF0, 40, 8'hFF, 4'h9);
		xfer(1'b1, dco_pkg::OFS_MULT, 32'h14);
		bper = 20;
		xfer(1'b1, dco_pkg::OFS_CTRL, 32'h0F);
		xfer(0, dco_pkg::OFS_CTRL, 32'h0);
		chk("monitor refused", 32'h0, {31'h0, q[3]});
		chk("stable dropped", 32'h0, {31'h0, q[5]});
		xfer(0, dco_pkg::OFS_MULT, 32'h0);
		chk("factor", 32'h14, {25'h0, q[6:0]});
		for (i = 0; i < 1000 && q[5] !== 1'b1; i++)
			xfer(0, dco_pkg::OFS_CTRL, 32'h0);
		if (i == 1000)
			hang();
		xfer(1'b1, dco_pkg::OFS_CTRL, 32'h0F);
		xfer(0, dco_pkg::OFS_CTRL, 32'h0);
		chk("monitor on", 32'h1, {31'h0, q[3]});
		ext_off <= 1'b1;
		for (i = 0; i < 20 && monitor_flag !== 1'b1; i++)
			@(posedge mclk);
		if (i == 20)
			hang();
		chk("flag", 32'h1, {31'h0, monitor_flag});
		chk("select", 32'h0, {31'h0, sel_external});
		ext_off <= 1'b0;
		xfer(0, dco_pkg::OFS_CTRL, 32'h0);
		chk("flag read", 32'h1, {31'h0, q[4]});
		xfer(1'b1, dco_pkg::OFS_CTRL, 32'h0E);
		@(posedge mclk);
		chk("flag cleared", 32'h0, {31'h0, monitor_flag});
		nrst <= 1'b0;
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		xfer(0, dco_pkg::OFS_CTRL, 32'h0);
		chk("ctrl", 32'h06, q & 32'h1F);
		xfer(0, dco_pkg::OFS_MULT, 32'h0);
		chk("mult", 32'h15, q & 32'h7F);
		xfer(0, dco_pkg::OFS_TRIM, 32'h0);
		chk("trim", 32'h80, q & 32'hFF);
		xfer(0, dco_pkg::OFS_STG, 32'h0);
		chk("stage reset", 32'h80, q & 32'hFF);
		xfer(0, 8'h18, 32'h0);
		chk("unmapped", 32'h1, {31'h0, e});
		stop_test();
	end
endmodule
